// File: hw/sfcap_top.sv
// Purpose: serial flash command and address front end with power-on handling
// Assumes: pins oversampled by a 200 MHz clock; sck well below clock / 4
// Notes: data phases after the header are passed bit by bit to the command logic
//
// Overview of operation
// - address: reserved, 13 page, 10 byte bits
// - read/write opcodes carry both fields, some dummies
// - buffer opcodes drop page bits, some dummies
// - page opcodes use full, upper, or no page
// - power-on or reset selects mode 3
// - output floats after reset until driven
// - instruction starts only after select falling edge
// - clock idle level at select picks mode
// - commands ignored during internal power-on reset
// - idle in standby after power-up
`default_nettype none

module sfcap_top #(
  parameter int SELECT_CYCLES = sfcap_pkg::SELECT_AFTER_SUPPLY_CYCLES,
  parameter int WRITE_CYCLES = sfcap_pkg::WRITE_AFTER_POWERUP_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe,
  input wire logic tx_enable,
  input wire logic tx_bit,
  output logic tx_shift,
  output logic cmd_strobe,
  output sfcap_pkg::sfcap_cmd_t cmd,
  output logic body_active,
  output logic rx_bit,
  output logic rx_valid,
  output logic spi_mode3,
  output logic por_active,
  output logic standby,
  output logic read_allowed,
  output logic write_allowed
);

  // header walk states
  typedef enum logic [2:0] {ST_WAIT_HIGH, ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY,
                            ST_BODY} sfcap_state_t;

  sfcap_pkg::sfcap_pins_t pins_raw;     // pins grouped for the synchroniser
  sfcap_pkg::sfcap_pins_t pins;         // synchronised pins
  sfcap_pkg::sfcap_opinfo_t op_info;    // decode of the opcode being completed
  sfcap_pkg::sfcap_opinfo_t info;       // decode held for the rest of the header
  sfcap_state_t state;                  // header position
  logic cs_prev;                        // edge detection history
  logic sck_prev;
  logic [7:0] op_shift;                 // opcode shift register
  logic [23:0] addr_shift;              // address shift register
  logic [5:0] bit_cnt;                  // bit index within the phase
  logic [2:0] settle_cnt;               // internal reset stretch
  logic [22:0] select_cnt;              // supply-to-select delay
  logic [22:0] write_cnt;               // power-up-to-write delay
  logic [6:0] hdr_bits;                 // helper: bits since select
  wire logic cs_fall = cs_prev & ~pins.cs_n;
  wire logic cs_rise = ~cs_prev & pins.cs_n;
  wire logic sck_rise = ~sck_prev & pins.sck & ~pins.cs_n;
  wire logic sck_fall = sck_prev & ~pins.sck & ~pins.cs_n;
  wire logic [7:0] next_opcode = {op_shift[6:0], pins.si};
  wire logic [23:0] next_addr = {addr_shift[22:0], pins.si};
  wire logic [5:0] dummy_last = 6'({info.dummy_bytes, 3'h0}) - 6'h01;

  assign pins_raw = '{cs_n: cs_n_pin, sck: sck_pin, si: si_pin};

  sfcap_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pins_in(pins_raw),
    .pins_out(pins)
  );

  sfcap_opdec u_opdec (
    .opcode(next_opcode),
    .info(op_info)
  );

  // build the handed-over command, masking bits that do not count
  function automatic sfcap_pkg::sfcap_cmd_t build_cmd(input logic [7:0] opc,
                                                      input sfcap_pkg::sfcap_opinfo_t oi,
                                                      input logic [23:0] addr);
    logic [12:0] pg;
    pg = addr[sfcap_pkg::PAGE_MSB:sfcap_pkg::PAGE_LSB];
    build_cmd.opcode = opc;
    unique case (oi.page_use)
      sfcap_pkg::PG_FULL: build_cmd.page_address_field = pg;
      sfcap_pkg::PG_UPPER10: build_cmd.page_address_field = pg & sfcap_pkg::PAGE_UPPER10_MASK;
      sfcap_pkg::PG_UPPER4: build_cmd.page_address_field = pg & sfcap_pkg::PAGE_UPPER4_MASK;
      sfcap_pkg::PG_NONE: build_cmd.page_address_field = 13'h0000;
    endcase
    build_cmd.byte_address = oi.use_byte ? addr[sfcap_pkg::BYTE_MSB:0] : 10'h000;
    build_cmd.page_valid = (oi.page_use != sfcap_pkg::PG_NONE);
    build_cmd.byte_valid = oi.use_byte;
    return build_cmd;
  endfunction

  // edge history of the synchronised pins
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_prev <= 1'b1;
      sck_prev <= 1'b1;
    end
    else
    begin
      cs_prev <= pins.cs_n;
      sck_prev <= pins.sck;
    end
  end

  // internal power-on reset, stretched until the synchronisers hold real pin levels
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      por_active <= 1'b1;
      settle_cnt <= 3'h0;
    end
    else if (por_active)
    begin
      settle_cnt <= settle_cnt + 3'h1;
      por_active <= (settle_cnt != sfcap_pkg::POR_SETTLE_LAST);
    end
  end

  // power-up delay status; the host must honour both before selecting or writing
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      select_cnt <= 23'h000000;
      read_allowed <= 1'b0;
    end
    else if (!por_active && !read_allowed)
    begin
      select_cnt <= select_cnt + 23'h000001;
      read_allowed <= (select_cnt == 23'(SELECT_CYCLES - 1));
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      write_cnt <= 23'h000000;
      write_allowed <= 1'b0;
    end
    else if (!por_active && !write_allowed)
    begin
      write_cnt <= write_cnt + 23'h000001;
      write_allowed <= (write_cnt == 23'(WRITE_CYCLES - 1));
    end
  end

  // clock mode: mode 3 out of reset, re-chosen at each accepted select
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      spi_mode3 <= sfcap_pkg::MODE3_RESET;
    else if (state == ST_IDLE && cs_fall)
      spi_mode3 <= pins.sck;
  end

  // header walk; a select already low when reset ends is not an instruction
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_WAIT_HIGH;
      op_shift <= 8'h00;
      addr_shift <= 24'h000000;
      bit_cnt <= 6'h00;
      info <= '0;
      cmd <= '0;
      cmd_strobe <= 1'b0;
    end
    else
    begin
      cmd_strobe <= 1'b0;
      if (por_active)
        state <= ST_WAIT_HIGH;
      else if (pins.cs_n)
        state <= ST_IDLE;
      else
      begin
        unique case (state)
          // waiting for select to go high first
          ST_WAIT_HIGH: state <= ST_WAIT_HIGH;
          // only a falling select opens an instruction
          ST_IDLE:
          begin
            if (cs_fall)
            begin
              state <= ST_OPCODE;
              bit_cnt <= 6'h00;
            end
          end
          // msb-first opcode
          ST_OPCODE:
          begin
            if (sck_rise)
            begin
              op_shift <= next_opcode;
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == sfcap_pkg::OPCODE_LAST)
              begin
                info <= op_info;
                bit_cnt <= 6'h00;
                if (op_info.has_addr)
                  state <= ST_ADDR;
                else
                begin
                  state <= ST_BODY;
                  cmd <= build_cmd(next_opcode, op_info, 24'h000000);
                  cmd_strobe <= op_info.known;
                end
              end
            end
          end
          // 24 address bits, reserved bit first and discarded later
          ST_ADDR:
          begin
            if (sck_rise)
            begin
              addr_shift <= next_addr;
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == sfcap_pkg::ADDR_LAST)
              begin
                bit_cnt <= 6'h00;
                if (info.dummy_bytes == 3'h0)
                begin
                  state <= ST_BODY;
                  cmd <= build_cmd(op_shift, info, next_addr);
                  cmd_strobe <= 1'b1;
                end
                else
                  state <= ST_DUMMY;
              end
            end
          end
          // don't-care bytes are counted, not stored
          ST_DUMMY:
          begin
            if (sck_rise)
            begin
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == dummy_last)
              begin
                state <= ST_BODY;
                cmd <= build_cmd(op_shift, info, addr_shift);
                cmd_strobe <= 1'b1;
              end
            end
          end
          ST_BODY: state <= ST_BODY;
        endcase
      end
    end
  end

  // data-phase bits passed on as they arrive
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_bit <= 1'b0;
      rx_valid <= 1'b0;
      body_active <= 1'b0;
    end
    else
    begin
      rx_valid <= (state == ST_BODY) && sck_rise;
      if ((state == ST_BODY) && sck_rise)
        rx_bit <= pins.si;
      body_active <= (state == ST_BODY) && !pins.cs_n;
    end
  end

  // output pin: floats until the command logic drives it, released at deselect
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      so_out <= 1'b0;
      so_oe <= sfcap_pkg::SO_OE_RESET;
      tx_shift <= 1'b0;
    end
    else
    begin
      tx_shift <= (state == ST_BODY) && tx_enable && sck_fall;
      if (pins.cs_n || por_active)
        so_oe <= 1'b0;
      else if ((state == ST_BODY) && tx_enable && sck_fall)
      begin
        so_out <= tx_bit;
        so_oe <= 1'b1;
      end
    end
  end

  // standby: out of reset and not selected
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      standby <= 1'b0;
    else
      standby <= !por_active && pins.cs_n;
  end

  // helper: bits clocked since the select edge
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      hdr_bits <= 7'h00;
    else if (pins.cs_n)
      hdr_bits <= 7'h00;
    else if (sck_rise && hdr_bits != 7'h7f)
      hdr_bits <= hdr_bits + 7'h01;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_mode_default: assert property (por_active |-> spi_mode3) else $error("mode not 3");
  a_so_float: assert property (por_active |=> !so_oe) else $error("output driven in reset");
  a_por_ignore: assert property (por_active |-> !cmd_strobe) else $error("cmd in reset");
  a_start_fall: assert property ($rose(state == ST_OPCODE) |-> $past(cs_fall))
    else $error("instruction without select fall");
  a_mode_pick: assert property (state == ST_IDLE && cs_fall && !pins.cs_n |=>
    spi_mode3 == $past(pins.sck)) else $error("mode not sampled");
  a_dummy_four: assert property (cmd_strobe && info.dummy_bytes == 3'h4 |->
    hdr_bits == 7'h40) else $error("four dummy length wrong");
  a_plain_len: assert property (cmd_strobe && cmd.byte_valid && info.dummy_bytes == 3'h0 |->
    hdr_bits == 7'h20) else $error("address length wrong");
  a_buffer_page: assert property (cmd_strobe && cmd.byte_valid && !cmd.page_valid |->
    cmd.page_address_field == 13'h0000) else $error("buffer page not ignored");
  a_upper_four: assert property (cmd_strobe && cmd.opcode == sfcap_pkg::OPC_7C |->
    cmd.page_address_field[8:0] == 9'h000) else $error("upper4 page wrong");
  a_standby_idle: assert property (standby |-> state != ST_BODY ##1 !body_active)
    else $error("standby while busy");

endmodule

`default_nettype wire

// File: common/sfcap_pkg.sv
// Purpose: shared constants and types for the serial flash command front end
// Assumes: 200 MHz system clock, 528-byte page addressing only
// Notes: all opcodes, field positions and delays, and the mode and output reset values, live here
`default_nettype none

package sfcap_pkg;

  // system clock rate and the power-up delays derived from it
  localparam int CLOCK_MHZ = 200;
  localparam int SELECT_AFTER_SUPPLY_DELAY_US = 50;      // least time, microseconds
  localparam int WRITE_AFTER_POWERUP_DELAY_MS = 20;      // longest time, milliseconds
  // least time rounds up; 50 us at 200 MHz divides exactly
  localparam int SELECT_AFTER_SUPPLY_CYCLES =
    (SELECT_AFTER_SUPPLY_DELAY_US * CLOCK_MHZ * 1000 + 999) / 1000;
  // longest time rounds down
  localparam int WRITE_AFTER_POWERUP_CYCLES = WRITE_AFTER_POWERUP_DELAY_MS * 1000 * CLOCK_MHZ;
  // last stretch count of the internal reset (four cycles) so the pin synchronisers settle
  localparam logic [2:0] POR_SETTLE_LAST = 3'h3;

  // address word layout: reserved bit, page field, byte/buffer field
  localparam int RESERVED_BIT = 23;
  localparam int PAGE_MSB = 22;
  localparam int PAGE_LSB = 10;
  localparam int BYTE_MSB = 9;
  localparam logic [12:0] PAGE_UPPER10_MASK = 13'h1ff8;
  localparam logic [12:0] PAGE_UPPER4_MASK = 13'h1e00;

  // last bit index of each header phase
  localparam logic [5:0] OPCODE_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h17;

  // reset values
  localparam logic MODE3_RESET = 1'b1;                   // mode 3 after power-on
  localparam logic SO_OE_RESET = 1'b0;                   // output floats after power-on

  // opcodes with page and byte fields
  localparam logic [7:0] OPC_03 = 8'h03, OPC_0B = 8'h0b, OPC_82 = 8'h82, OPC_85 = 8'h85,
    OPC_D2 = 8'hd2, OPC_E8 = 8'he8;
  // buffer-only opcodes
  localparam logic [7:0] OPC_84 = 8'h84, OPC_87 = 8'h87, OPC_D1 = 8'hd1, OPC_D3 = 8'hd3,
    OPC_D4 = 8'hd4, OPC_D6 = 8'hd6;
  // page-level opcodes
  localparam logic [7:0] OPC_53 = 8'h53, OPC_55 = 8'h55, OPC_58 = 8'h58, OPC_59 = 8'h59,
    OPC_60 = 8'h60, OPC_61 = 8'h61, OPC_81 = 8'h81, OPC_83 = 8'h83, OPC_86 = 8'h86,
    OPC_88 = 8'h88, OPC_89 = 8'h89, OPC_50 = 8'h50, OPC_7C = 8'h7c, OPC_77 = 8'h77;
  // opcodes with no address bytes
  localparam logic [7:0] OPC_9F = 8'h9f, OPC_B9 = 8'hb9, OPC_AB = 8'hab, OPC_D7 = 8'hd7;

  // how much of the page field an opcode uses
  typedef enum logic [1:0] {PG_NONE, PG_FULL, PG_UPPER10, PG_UPPER4} sfcap_page_use_t;

  // decoded opcode properties
  typedef struct packed {
    logic known;                       // opcode is recognised
    logic has_addr;                    // three address bytes follow
    sfcap_page_use_t page_use;         // page bits that count
    logic use_byte;                    // byte/buffer field counts
    logic [2:0] dummy_bytes;           // don't-care bytes after the address
  } sfcap_opinfo_t;

  // completed command header handed to the command logic
  typedef struct packed {
    logic [7:0] opcode;
    logic [12:0] page_address_field;
    logic [9:0] byte_address;
    logic page_valid;
    logic byte_valid;
  } sfcap_cmd_t;

  // raw serial pins as sampled
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } sfcap_pins_t;

endpackage

`default_nettype wire

// File: hw/sfcap_sync.sv
// Purpose: two-flop synchroniser for the serial pins
// Assumes: pins are asynchronous to clock
// Notes: first stage is read only by the second stage
`default_nettype none

module sfcap_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire sfcap_pkg::sfcap_pins_t pins_in,
  output sfcap_pkg::sfcap_pins_t pins_out
);

  sfcap_pkg::sfcap_pins_t stage1;   // metastable stage, not used elsewhere

  // reset to idle pin levels: deselected, clock high as in mode 3
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1 <= 3'h6;
      pins_out <= 3'h6;
    end
    else
    begin
      stage1 <= pins_in;
      pins_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// File: hw/sfcap_opdec.sv
// Purpose: classify an opcode into address use and dummy byte count
// Assumes: 528-byte page addressing
// Notes: purely combinational; unknown opcodes are marked not known
`default_nettype none

module sfcap_opdec (
  input wire logic [7:0] opcode,
  output sfcap_pkg::sfcap_opinfo_t info
);

  // one lookup per opcode; default catches every unlisted code
  always_comb
  begin
    info = '{known: 1'b1, has_addr: 1'b1, page_use: sfcap_pkg::PG_NONE,
             use_byte: 1'b0, dummy_bytes: 3'h0};
    unique case (opcode)
      // page and byte fields
      sfcap_pkg::OPC_03, sfcap_pkg::OPC_82, sfcap_pkg::OPC_85:
      begin
        info.page_use = sfcap_pkg::PG_FULL;
        info.use_byte = 1'b1;
      end
      sfcap_pkg::OPC_0B:
      begin
        info.page_use = sfcap_pkg::PG_FULL;
        info.use_byte = 1'b1;
        info.dummy_bytes = 3'h1;
      end
      sfcap_pkg::OPC_D2, sfcap_pkg::OPC_E8:
      begin
        info.page_use = sfcap_pkg::PG_FULL;
        info.use_byte = 1'b1;
        info.dummy_bytes = 3'h4;
      end
      // buffer only: page bits ignored
      sfcap_pkg::OPC_84, sfcap_pkg::OPC_87, sfcap_pkg::OPC_D1, sfcap_pkg::OPC_D3:
        info.use_byte = 1'b1;
      sfcap_pkg::OPC_D4, sfcap_pkg::OPC_D6:
      begin
        info.use_byte = 1'b1;
        info.dummy_bytes = 3'h1;
      end
      // page level
      sfcap_pkg::OPC_53, sfcap_pkg::OPC_55, sfcap_pkg::OPC_58, sfcap_pkg::OPC_59,
      sfcap_pkg::OPC_60, sfcap_pkg::OPC_61, sfcap_pkg::OPC_81, sfcap_pkg::OPC_83,
      sfcap_pkg::OPC_86, sfcap_pkg::OPC_88, sfcap_pkg::OPC_89:
        info.page_use = sfcap_pkg::PG_FULL;
      sfcap_pkg::OPC_50:
        info.page_use = sfcap_pkg::PG_UPPER10;
      sfcap_pkg::OPC_7C:
        info.page_use = sfcap_pkg::PG_UPPER4;
      sfcap_pkg::OPC_77:
        info.page_use = sfcap_pkg::PG_NONE;
      // no address bytes at all
      sfcap_pkg::OPC_9F, sfcap_pkg::OPC_B9, sfcap_pkg::OPC_AB, sfcap_pkg::OPC_D7:
        info.has_addr = 1'b0;
      default:
      begin
        info.known = 1'b0;
        info.has_addr = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: verification/sfcap_host.sv
// Purpose: host serial master model driving select, clock and data pins
// Assumes: paced by the bench clock; half sets clocks per sck half period
// Notes: data line shows the inverse of its last bit while deselected
`default_nettype none

module sfcap_host (
  input wire logic clock,
  output logic cs_n,
  output logic sck,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 3; // raise for a slow host; 3 keeps the edge detector happy

  // idle: deselected, clock high as after power-up
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end

  // one sck period: fall with new data, then rise where the device samples
  task automatic bit_out(input logic b);
    @(posedge clock);
    sck <= 1'b0;
    si <= b; // msb first
    repeat (half) @(posedge clock);
    sck <= 1'b1;
    repeat (half) @(posedge clock);
  endtask

  // set idle clock level, select, then shift the frame from its top bit
  task automatic send(input logic idle, input logic [63:0] frame, input int nbits);
    @(posedge clock);
    sck <= idle;
    repeat (2 * half) @(posedge clock);
    cs_n <= 1'b0; // falling edge opens each instruction
    repeat (2 * half) @(posedge clock);
    for (int i = 0; i < nbits; i++)
      bit_out(frame[63 - i]); // opcode, reserved, page, byte, dummies in order
  endtask

  // select without a frame, used to hold select low across a reset
  task automatic select_only();
    @(posedge clock);
    cs_n <= 1'b0;
  endtask

  // deselect; flip data so a stale bit is never read as valid
  task automatic done();
    @(posedge clock);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (4 * half) @(posedge clock);
  endtask

  // hold off after power-up before reads and writes
  task automatic power_wait(input int cycles);
    repeat (cycles) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// File: verification/sfcap_top_tb_top.sv
// Purpose: self-checking bench for the serial flash command front end
// Assumes: 200 MHz clock, shortened power-up counts of 20 and 40 cycles
// Notes: strobe and body bit counts are kept by the bench, not the design
`default_nettype none

module sfcap_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, tx_enable, tx_bit, cs_n, sck, si, so_out, so_oe, tx_shift;
  logic cmd_strobe, body_active, rx_bit, rx_valid, spi_mode3, por_active, standby;
  logic read_allowed, write_allowed;
  sfcap_pkg::sfcap_cmd_t cmd;
  int n_errors = 0;
  int checks_done = 0;
  int n_strobe = 0; // header strobes seen
  int n_rx = 0; // body bits seen
  int n_tx = 0; // output bits taken

  sfcap_top #(.SELECT_CYCLES(20), .WRITE_CYCLES(40)) uut (.clock(clock), .sys_rst(sys_rst),
    .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .so_out(so_out), .so_oe(so_oe),
    .tx_enable(tx_enable), .tx_bit(tx_bit), .tx_shift(tx_shift), .cmd_strobe(cmd_strobe),
    .cmd(cmd), .body_active(body_active), .rx_bit(rx_bit), .rx_valid(rx_valid),
    .spi_mode3(spi_mode3), .por_active(por_active), .standby(standby),
    .read_allowed(read_allowed), .write_allowed(write_allowed));
  sfcap_host host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));

  // 5 ns clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // pulse counters
  always @(posedge clock)
  begin
    if (cmd_strobe === 1'b1)
      n_strobe++;
    if (rx_valid === 1'b1)
      n_rx++;
    if (tx_shift === 1'b1)
      n_tx++;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // reset values, internal reset release, standby and hold-off flags
  task automatic test_reset();
    int i;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    check(so_oe === 1'b0, "output driven in reset");
    check(spi_mode3 === 1'b1, "mode after reset");
    check(por_active === 1'b1, "internal reset flag low");
    sys_rst <= 1'b0;
    for (i = 0; i < 20 && standby !== 1'b1; i++)
      @(posedge clock);
    check(standby === 1'b1 && por_active === 1'b0, "no standby");
    if (i == 20)
      stop_test();
    host.power_wait(10);
    check(read_allowed === 1'b0 && write_allowed === 1'b0, "flags too early");
    host.power_wait(20);
    check(read_allowed === 1'b1 && write_allowed === 1'b0, "flags out of order");
    host.power_wait(20);
    check(read_allowed === 1'b1 && write_allowed === 1'b1, "flags too late");
    check(so_oe === 1'b0, "output driven in standby");
    $display("test reset done");
  endtask

  // select already low at reset release, then an unknown opcode
  task automatic test_held_select();
    int n0;
    sys_rst <= 1'b1;
    host.select_only();
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    n0 = n_strobe;
    host.send(1'b1, {8'h03, 56'h0}, 32);
    host.done();
    check(n_strobe == n0, "header without select edge");
    host.send(1'b1, {8'hff, 56'h0}, 32);
    host.done();
    check(n_strobe == n0, "unknown opcode strobed");
    host.power_wait(50);
    $display("test held select done");
  endtask

  // one header; pg 0 none, 1 full, 2 upper ten, 3 upper four page bits
  task automatic run_op(input logic [7:0] opc, input int pg, input logic bv, input int nd,
    input int na, input logic idle);
    logic [23:0] a;
    logic [12:0] pmask;
    logic [63:0] f;
    int n0;
    int nb;
    a = 24'h6b5a97; // reserved top bit sent as zero
    pmask = pg == 1 ? 13'h1fff : pg == 2 ? 13'h1ff8 : pg == 3 ? 13'h1e00 : 13'h0000;
    f = {opc, a, 32'h0};
    nb = na ? 8 : 32 + 8 * nd;
    n0 = n_strobe;
    host.send(idle, f, nb - 1);
    repeat (8) @(posedge clock);
    check(n_strobe == n0, "strobe before header end");
    host.bit_out(f[64 - nb]);
    repeat (10) @(posedge clock);
    check(n_strobe == n0 + 1, "header strobe missing");
    check(cmd.opcode === opc && spi_mode3 === idle, "opcode or mode");
    check(cmd.page_valid === (pg != 0) && cmd.byte_valid === bv, "valid flags");
    check(cmd.page_address_field === (a[22:10] & pmask), "page field");
    if (bv)
      check(cmd.byte_address === a[9:0], "byte field");
    host.done();
  endtask

  // every documented opcode, alternating mode 0 and mode 3
  task automatic test_table();
    logic [7:0] both_ops [6] = '{8'h03, 8'h0b, 8'h82, 8'h85, 8'hd2, 8'he8};
    int both_nd [6] = '{0, 1, 0, 0, 4, 4};
    logic [7:0] buf_ops [6] = '{8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6};
    int buf_nd [6] = '{0, 0, 0, 0, 1, 1};
    logic [7:0] page_ops [11] = '{8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61, 8'h81, 8'h83,
      8'h86, 8'h88, 8'h89};
    logic [7:0] part_ops [3] = '{8'h50, 8'h7c, 8'h77};
    int part_pg [3] = '{2, 3, 0};
    logic [7:0] bare_ops [4] = '{8'h9f, 8'hb9, 8'hab, 8'hd7};
    foreach (both_ops[i])
      run_op(both_ops[i], 1, 1'b1, both_nd[i], 0, i[0]);
    foreach (buf_ops[i])
      run_op(buf_ops[i], 0, 1'b1, buf_nd[i], 0, i[0]);
    foreach (page_ops[i])
      run_op(page_ops[i], 1, 1'b0, 0, 0, i[0]);
    foreach (part_ops[i])
      run_op(part_ops[i], part_pg[i], 1'b0, 0, 0, i[0]);
    foreach (bare_ops[i])
      run_op(bare_ops[i], 0, 1'b0, 0, 1, i[0]);
    $display("test table done");
  endtask

  // body after a fast read header: output drive, body bits, float on deselect
  task automatic test_body();
    int n0;
    int n1;
    host.send(1'b0, {8'h0b, 24'h000123, 32'h0}, 40);
    n0 = n_rx;
    n1 = n_tx;
    tx_enable <= 1'b1;
    tx_bit <= 1'b1;
    repeat (5) host.bit_out(1'b0);
    host.bit_out(1'b1);
    repeat (4) @(posedge clock);
    check(body_active === 1'b1 && so_oe === 1'b1 && so_out === 1'b1, "body output");
    check(n_rx - n0 == 6 && rx_bit === 1'b1, "body bits");
    check(n_tx - n1 == 6, "output bit count");
    host.done();
    tx_enable <= 1'b0;
    check(so_oe === 1'b0 && body_active === 1'b0, "output after deselect");
    $display("test body done");
  endtask

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    tx_enable = 1'b0;
    tx_bit = 1'b0;
    test_reset();
    test_held_select();
    test_table();
    test_body();
    stop_test();
  end

  // hang guard
  initial
  begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule

`default_nettype wire
